// ### core/cpw_pkg.sv
package cpw_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_TIMEOUT = 12'h0b04;
  localparam logic [11:0] ADDR_STATUS = 12'h0b08;
  localparam logic [11:0] ADDR_EXP_ID = 12'h0b0c;
  localparam logic [11:0] ADDR_EXP_LEN = 12'h0b10;
  localparam logic [11:0] ADDR_CTRL = 12'h0b00;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h0b40;
  // reset values
  localparam logic [31:0] RST_TIMEOUT = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0000_0080;
  localparam logic [31:0] RST_EXP_ID = 32'h0000_0000;
  localparam logic [31:0] RST_EXP_LEN = 32'h0000_0008;
  // field positions
  localparam int TO_FLAG_BIT = 17;
  localparam int MATCH_FLAG_BIT = 16;
  localparam int CNT_LSB = 8;
  localparam int CNT_VALID_BIT = 7;
  localparam int EXP_FMT_BIT = 30;
  localparam int EXP_RTR_BIT = 29;
  localparam int LEN_LO_LSB = 16;
  localparam int LEN_HI_LSB = 0;
  localparam int STD_ID_LSB = 18;
  // control register fields
  localparam int CTRL_FFT_LSB = 0;
  localparam int CTRL_IDENTIFIER_FILTER_TYPE_LSB = 2;
  localparam int CTRL_NMM_LSB = 8;
  localparam logic [31:0] RST_CTRL = 32'h0000_0100;
  localparam logic [31:0] CTRL_MASK = 32'h0000_ff0f;
  // bit times per timeout step
  localparam int TO_STEP_BITS = 64;
  typedef enum logic [1:0] {CPW_IDLE, CPW_COUNT} cpw_cnt_state_t;
endpackage

// ### core/cpw_frame_match.sv
module cpw_frame_match (
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic rx_rtr_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [28:0] exp_id_i,
  input wire logic exp_ext_i,
  input wire logic exp_rtr_i,
  input wire logic [28:0] id_high_i,
  input wire logic [1:0] id_type_i,
  input wire logic [1:0] frame_type_i,
  input wire logic [3:0] len_lo_i,
  input wire logic [3:0] len_hi_i,
  input wire logic data_ok_i,
  output logic match_o
);
  logic [28:0] id_mask;
  logic [28:0] rid;
  logic [28:0] eid;
  logic id_ok;
  logic len_ok;
  logic fields_all;

  always_comb begin
    // standard frames only carry bits 28:18
    id_mask = rx_ext_i ? 29'h1fff_ffff : 29'h1ffc_0000;
    rid = rx_id_i & id_mask;
    eid = exp_id_i & id_mask;
    case (id_type_i)
      2'b11: id_ok = (rid >= eid) && (rid <= (id_high_i & id_mask));
      2'b00: id_ok = ((rid ^ eid) & id_high_i & id_mask) == 29'h0000_0000;
      default: id_ok = (rid == eid);
    endcase
    len_ok = (rx_dlc_i >= len_lo_i) && (rx_dlc_i <= len_hi_i);
    fields_all = len_ok && data_ok_i;
    match_o = id_ok && (rx_ext_i == exp_ext_i) && (rx_rtr_i == exp_rtr_i)
              && (frame_type_i[0] ? fields_all : 1'b1);
  end
endmodule

// ### core/cpw_regs.sv
// Overview of operation
// - Timeout, expected identifier and length registers are writable only in inactive mode.
// - The 16-bit timeout counts in steps of 64 bit times and zero disables it.
// - Status bit 17 sets on a wakeup timeout and clears on a written one.
// - Status bit 16 sets on a wakeup match and clears on a written one.
// - An 8-bit count of matching messages reads in status bits 15:8.
// - The count clears on entry to partial-network mode and ignores software reset.
// - Status bit 7 reads 0 while the count updates and 1 when valid, 1 after reset.
// - Expected format bit 30 selects standard or extended frames.
// - Expected remote bit 29 selects data or remote frames.
// - The 29-bit identifier is exact for filter types 1 and 2, compared under the id_high_i mask for type 0 and a range up to id_high_i for type 3.
// - Extended frames compare all 29 bits, standard frames only bits 28:18.
// - Length bounds sit in bits 19:16 (lower) and 3:0 (upper).
// - The expected length register resets to 0x0000_0008.
// - Frame filter type selects field set and whether the match count is required.
module cpw_regs #(
  parameter int TO_WIDTH = 16,
  parameter int CNT_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic inactive_mode_i,
  input wire logic pn_mode_i,
  input wire logic soft_reset_i,
  input wire logic bit_tick_i,
  input wire logic rx_valid_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic rx_rtr_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic rx_data_ok_i,
  input wire logic [28:0] id_high_i,
  output logic wakeup_o,
  output logic irq_o
);
  logic [TO_WIDTH-1:0] wake_timeout_value;
  logic [31:0] exp_id_reg;
  logic [3:0] length_lower_bound;
  logic [3:0] length_upper_bound;
  logic [31:0] ctrl_reg;
  logic [1:0] irq_mask;
  logic wake_timeout_flag;
  logic wake_match_flag;
  logic [CNT_WIDTH-1:0] match_message_count;
  logic match_count_valid;
  logic pn_mode_q;
  logic pn_enter;
  logic [5:0] bit_cnt;
  logic [TO_WIDTH-1:0] step_cnt;
  logic timeout_evt;
  logic frame_match;
  logic match_evt;
  logic req;
  logic wr_ok;
  logic cfg_wr;
  logic clr_to;
  logic clr_match;
  logic [1:0] frame_filter_type;
  logic [1:0] identifier_filter_type;
  logic [CNT_WIDTH-1:0] required_match_count;
  logic [31:0] next_rdata;
  cpw_pkg::cpw_cnt_state_t state;

  assign frame_filter_type = ctrl_reg[cpw_pkg::CTRL_FFT_LSB +: 2];
  assign identifier_filter_type = ctrl_reg[cpw_pkg::CTRL_IDENTIFIER_FILTER_TYPE_LSB +: 2];
  assign required_match_count = ctrl_reg[cpw_pkg::CTRL_NMM_LSB +: CNT_WIDTH];

  // single-cycle answer; ack drops the cycle after it was given
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ok = req && wb_we_i && (wb_sel_i == 4'hf);
  assign cfg_wr = wr_ok && inactive_mode_i;
  assign clr_to = wr_ok && (wb_adr_i == cpw_pkg::ADDR_STATUS)
                  && wb_dat_i[cpw_pkg::TO_FLAG_BIT];
  assign clr_match = wr_ok && (wb_adr_i == cpw_pkg::ADDR_STATUS)
                     && wb_dat_i[cpw_pkg::MATCH_FLAG_BIT];
  assign pn_enter = pn_mode_i && !pn_mode_q;

  cpw_frame_match u_match (
    .rx_id_i(rx_id_i),
    .rx_ext_i(rx_ext_i),
    .rx_rtr_i(rx_rtr_i),
    .rx_dlc_i(rx_dlc_i),
    .exp_id_i(exp_id_reg[28:0]),
    .exp_ext_i(exp_id_reg[cpw_pkg::EXP_FMT_BIT]),
    .exp_rtr_i(exp_id_reg[cpw_pkg::EXP_RTR_BIT]),
    .id_high_i(id_high_i),
    .id_type_i(identifier_filter_type),
    .frame_type_i(frame_filter_type),
    .len_lo_i(length_lower_bound),
    .len_hi_i(length_upper_bound),
    .data_ok_i(rx_data_ok_i),
    .match_o(frame_match)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pn_mode_q <= 1'b0;
    end else begin
      pn_mode_q <= pn_mode_i;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_timeout_value <= cpw_pkg::RST_TIMEOUT[TO_WIDTH-1:0];
      exp_id_reg <= cpw_pkg::RST_EXP_ID;
      length_lower_bound <= cpw_pkg::RST_EXP_LEN[cpw_pkg::LEN_LO_LSB +: 4];
      length_upper_bound <= cpw_pkg::RST_EXP_LEN[cpw_pkg::LEN_HI_LSB +: 4];
      ctrl_reg <= cpw_pkg::RST_CTRL;
      irq_mask <= 2'b00;
    end else if (wr_ok) begin
      if (cfg_wr && wb_adr_i == cpw_pkg::ADDR_TIMEOUT) begin
        wake_timeout_value <= wb_dat_i[TO_WIDTH-1:0];
      end
      if (cfg_wr && wb_adr_i == cpw_pkg::ADDR_EXP_ID) begin
        exp_id_reg <= {1'b0, wb_dat_i[30:0]};
      end
      if (cfg_wr && wb_adr_i == cpw_pkg::ADDR_EXP_LEN) begin
        length_lower_bound <= wb_dat_i[cpw_pkg::LEN_LO_LSB +: 4];
        length_upper_bound <= wb_dat_i[cpw_pkg::LEN_HI_LSB +: 4];
      end
      if (cfg_wr && wb_adr_i == cpw_pkg::ADDR_CTRL) begin
        ctrl_reg <= wb_dat_i & cpw_pkg::CTRL_MASK;
      end
      if (wb_adr_i == cpw_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= wb_dat_i[cpw_pkg::TO_FLAG_BIT -: 2];
      end
    end
  end

  // timeout: 64 bit times per step, restarted by each match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= cpw_pkg::CPW_IDLE;
      bit_cnt <= 6'h00;
      step_cnt <= '0;
      timeout_evt <= 1'b0;
    end else begin
      timeout_evt <= 1'b0;
      case (state)
        cpw_pkg::CPW_IDLE: begin
          bit_cnt <= 6'h00;
          step_cnt <= '0;
          if (pn_mode_i && wake_timeout_value != '0) begin
            state <= cpw_pkg::CPW_COUNT;
          end
        end
        cpw_pkg::CPW_COUNT: begin
          if (!pn_mode_i || match_evt) begin
            state <= cpw_pkg::CPW_IDLE;
          end else if (bit_tick_i) begin
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == 6'(cpw_pkg::TO_STEP_BITS - 1)) begin
              if (step_cnt + 1'b1 >= wake_timeout_value) begin
                timeout_evt <= 1'b1;
                state <= cpw_pkg::CPW_IDLE;
              end else begin
                step_cnt <= step_cnt + 1'b1;
              end
            end
          end
        end
        default: state <= cpw_pkg::CPW_IDLE;
      endcase
    end
  end

  // matching message counter; a match is raised once enough frames agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_message_count <= '0;
      match_count_valid <= 1'b1;
      match_evt <= 1'b0;
    end else begin
      match_evt <= 1'b0;
      match_count_valid <= 1'b1;
      if (pn_enter) begin
        match_message_count <= '0;
      end else if (pn_mode_i && rx_valid_i && frame_match) begin
        match_message_count <= match_message_count + 1'b1;
        match_count_valid <= 1'b0;
        if (!frame_filter_type[1] ||
            (match_message_count + 1'b1) >= required_match_count) begin
          match_evt <= 1'b1;
        end
      end
      // soft_reset_i deliberately does not touch the count
    end
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_timeout_flag <= 1'b0;
      wake_match_flag <= 1'b0;
    end else begin
      if (timeout_evt) begin
        wake_timeout_flag <= 1'b1;
      end else if (clr_to) begin
        wake_timeout_flag <= 1'b0;
      end
      if (match_evt) begin
        wake_match_flag <= 1'b1;
      end else if (clr_match) begin
        wake_match_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      wakeup_o <= 1'b0;
    end else begin
      irq_o <= |({wake_timeout_flag, wake_match_flag} & irq_mask);
      wakeup_o <= wake_timeout_flag || wake_match_flag;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      cpw_pkg::ADDR_TIMEOUT: next_rdata[TO_WIDTH-1:0] = wake_timeout_value;
      cpw_pkg::ADDR_STATUS: begin
        next_rdata[cpw_pkg::TO_FLAG_BIT] = wake_timeout_flag;
        next_rdata[cpw_pkg::MATCH_FLAG_BIT] = wake_match_flag;
        next_rdata[cpw_pkg::CNT_LSB +: CNT_WIDTH] = match_message_count;
        next_rdata[cpw_pkg::CNT_VALID_BIT] = match_count_valid;
      end
      cpw_pkg::ADDR_EXP_ID: next_rdata = exp_id_reg;
      cpw_pkg::ADDR_EXP_LEN: begin
        next_rdata[cpw_pkg::LEN_LO_LSB +: 4] = length_lower_bound;
        next_rdata[cpw_pkg::LEN_HI_LSB +: 4] = length_upper_bound;
      end
      cpw_pkg::ADDR_CTRL: next_rdata = ctrl_reg;
      cpw_pkg::ADDR_IRQ_MASK: next_rdata[cpw_pkg::TO_FLAG_BIT -: 2] = irq_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      wb_dat_o <= next_rdata;
    end
  end
endmodule

// ### sim/cpw_regs_asserts.sv
module cpw_regs_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wakeup_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !wakeup_o)
    else $error("outputs active after reset");
  stat_rsvd_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h0b08)
    |-> wb_dat_o[31:18] == 14'h0 && wb_dat_o[6:0] == 7'h0) else $error("status reserved set");
  len_rsvd_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h0b10)
    |-> (wb_dat_o & 32'hfff0_fff0) == 32'h0) else $error("length reserved set");
  tmo_rsvd_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h0b04)
    |-> wb_dat_o[31:16] == 16'h0) else $error("timeout reserved set");
  id_rsvd_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h0b0c)
    |-> !wb_dat_o[31]) else $error("identifier bit 31 set");
  irq_wake_a: assert property (irq_o |-> wakeup_o) else $error("irq without wake flag");
endmodule

// ### sim/cpw_can_node.sv
module cpw_can_node (
  input wire logic clk_i,
  output logic tick_o,
  output logic vld_o,
  output logic [28:0] id_o,
  output logic ext_o,
  output logic rtr_o,
  output logic [3:0] dlc_o,
  output logic dok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div;
  initial begin
    div = 2'h0;
    tick_o = 1'b0;
    vld_o = 1'b0;
    {id_o, ext_o, rtr_o, dlc_o, dok_o} = 36'h0;
  end
  // four clocks a bit time keeps 64-bit steps short
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    tick_o <= div == 2'h3;
  end
  // fields show inverted values after the valid cycle
  task automatic send(input logic [28:0] id, input logic e, input logic r, input logic [3:0] l);
    vld_o <= 1'b1;
    {id_o, ext_o, rtr_o, dlc_o, dok_o} <= {id, e, r, l, 1'b1};
    @(posedge clk_i);
    vld_o <= 1'b0;
    {id_o, ext_o, rtr_o, dlc_o, dok_o} <= ~{id, e, r, l, 1'b1};
  endtask
endmodule

// ### sim/test_cpw_regs.sv
module test_cpw_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] EID = 32'h0ab4_1234;
  logic clk_i, rst_i, cyc, stb, we, inact, pn, srst, ack, wake, irq, tick, vld, ext, rtr, dok;
  logic [11:0] adr;
  logic [3:0] sel, dlc;
  logic [31:0] wdat, rdat, q, d, r;
  logic [28:0] rid, fid, idh;
  logic [7:0] cnt;
  logic mf, tf, fe, ft;
  int mismatches, n_checks, seed, k;
  cpw_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .inactive_mode_i(inact), .pn_mode_i(pn), .soft_reset_i(srst), .bit_tick_i(tick),
    .rx_valid_i(vld), .rx_id_i(rid), .rx_ext_i(ext), .rx_rtr_i(rtr), .rx_dlc_i(dlc),
    .rx_data_ok_i(dok), .id_high_i(idh), .wakeup_o(wake), .irq_o(irq));
  cpw_can_node i_node (.clk_i(clk_i), .tick_o(tick), .vld_o(vld), .id_o(rid), .ext_o(ext),
    .rtr_o(rtr), .dlc_o(dlc), .dok_o(dok));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, dd, s};
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dd);
    wb(1'b1, a, dd, 4'hf);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, q);
  endtask
  function automatic logic [31:0] stat();
    return {14'h0, tf, mf, cnt, 1'b1, 7'h0};
  endfunction
  // expected setup: standard data frame, exact identifier
  function automatic logic hit(input logic [28:0] i, input logic e, input logic t);
    return !e && !t && i[28:18] == EID[28:18];
  endfunction
  // second setup: extended data frame, identifier range, length window 2 to 6
  function automatic logic hit2(input logic [28:0] i, input logic e, input logic t,
    input logic [3:0] l);
    return e && !t && i >= EID[28:0] && i <= idh && l >= 4'h2 && l <= 4'h6;
  endfunction
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h9d64;
    {rst_i, inact, cyc, stb, we, pn, srst, adr, sel, wdat} = {2'b11, 53'h0};
    {mismatches, n_checks, cnt, mf, tf} = 0;
    idh = 29'h1fff_ffff;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", 12'hb00, cpw_pkg::RST_CTRL);
    rd("timeout", 12'hb04, cpw_pkg::RST_TIMEOUT);
    rd("status", 12'hb08, cpw_pkg::RST_STATUS);
    rd("exp_id", 12'hb0c, cpw_pkg::RST_EXP_ID);
    rd("exp_len", 12'hb10, cpw_pkg::RST_EXP_LEN);
    rd("mask", 12'hb40, 32'h0);
    rd("unmapped", 12'hb44, 32'h0);
    for (k = 0; k < 4; k++) begin
      d = $random(seed);
      wr(12'hb04, d);
      rd("timeout", 12'hb04, d & 32'h0000_ffff);
      wr(12'hb10, d);
      rd("exp_len", 12'hb10, d & 32'h000f_000f);
    end
    wb(1'b1, 12'hb10, ~d, 4'h7);
    rd("partial", 12'hb10, d & 32'h000f_000f);
    wr(12'hb04, 32'h0);
    wr(12'hb0c, EID);
    wr(12'hb00, 32'h0000_0104);
    inact <= 1'b0;
    wr(12'hb0c, ~EID);
    rd("locked", 12'hb0c, EID);
    pn <= 1'b1;
    for (k = 0; k < 16; k++) begin
      r = $random(seed);
      fid = {r[24] ? EID[28:18] : r[10:0], r[31:14]};
      {fe, ft} = {r[11] & r[12], r[13] & r[25]};
      @(posedge clk_i);
      i_node.send(fid, fe, ft, r[29:26]);
      if (hit(fid, fe, ft)) {cnt, mf} = {cnt + 8'h1, 1'b1};
      repeat (3) @(posedge clk_i);
      rd("status", 12'hb08, stat());
    end
    chk("irq", 32'h0, {31'h0, irq});
    chk("wake", {31'h0, mf}, {31'h0, wake});
    wr(12'hb40, 32'h0003_0000);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, mf}, {31'h0, irq});
    srst <= 1'b1;
    @(posedge clk_i);
    srst <= 1'b0;
    wr(12'hb08, 32'h0);
    rd("status", 12'hb08, stat());
    wr(12'hb08, 32'h0001_0000);
    mf = 1'b0;
    rd("status", 12'hb08, stat());
    {pn, inact} <= 2'b01;
    wr(12'hb04, 32'h0000_0002);
    {pn, inact} <= 2'b10;
    cnt = 8'h0;
    rd("status", 12'hb08, stat());
    repeat (400) @(posedge clk_i);
    rd("status", 12'hb08, stat());
    repeat (200) @(posedge clk_i);
    tf = 1'b1;
    rd("status", 12'hb08, stat());
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'hb08, 32'h0002_0000);
    tf = 1'b0;
    rd("status", 12'hb08, stat());
    // range filter with length window, a wake needs two matching frames
    {pn, inact} <= 2'b01;
    wr(12'hb04, 32'h0);
    wr(12'hb0c, EID | 32'h4000_0000);
    wr(12'hb10, 32'h0002_0006);
    wr(12'hb00, 32'h0000_020f);
    {pn, inact} <= 2'b10;
    idh <= EID[28:0] + 29'h0000_0100;
    cnt = 8'h0;
    for (k = 0; k < 12; k++) begin
      r = $random(seed);
      fid = EID[28:0] - 29'h0000_0040 + {21'h0, r[8:1]};
      {fe, ft} = {r[0] | r[11], r[12] & r[13]};
      @(posedge clk_i);
      i_node.send(fid, fe, ft, r[29:26]);
      if (hit2(fid, fe, ft, r[29:26])) {cnt, mf} = {cnt + 8'h1, mf | (cnt >= 8'h1)};
      repeat (3) @(posedge clk_i);
      rd("status", 12'hb08, stat());
    end
    chk("wake", {31'h0, mf}, {31'h0, wake});
    tally_and_finish();
  end
endmodule
bind cpw_regs cpw_regs_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wakeup_o(wakeup_o), .irq_o(irq_o));
